// ### rtl/dcc_channel.sv
// Purpose: One DMA channel: setup registers, transfer engine, descriptor chaining.
// Assumes: APB slave with one wait state; simple req/ack memory master port.
// Notes: Each beat reads one item into the FIFO and writes it out again.
//
// Implementation choices: register access over APB and the register addresses.
module dcc_channel #(
  parameter int NREQ   = 16,
  parameter int FDEPTH = 4
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [NREQ-1:0]       periph_req,
  output dcc_pkg::dcc_mem_req_s      mem_o,
  input  wire logic                  mem_ack,
  input  wire logic [31:0]           mem_rdata,
  input  wire logic                  mem_err,
  output logic                       done_irq,
  output logic                       fault_irq
);
  import dcc_pkg::*;

  typedef struct packed {
    logic [31:0]   src;
    logic [31:0]   dst;
    logic [31:0]   nxt;
    logic [31:0]   ctrl;
    logic [31:0]   fptr;
    logic          halt;
    logic          lock;
    logic          done_en;
    logic          fault_en;
    logic [2:0]    flow;
    logic [3:0]    wsel;
    logic [3:0]    rsel;
    logic          en;
    logic          done_st;
    logic          fault_st;
    logic          stuck;
    logic          unsafe;
    dcc_state_e    st;
    logic [11:0]   left;
    logic [2:0]    beat;
    logic [1:0]    widx;
    dcc_mem_req_s  mem;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    logic          done_irq;
    logic          fault_irq;
  } dcc_core_s;

  dcc_core_s   r;
  dcc_core_s   n;
  logic        go;
  logic        active;
  logic        full;
  logic [31:0] fifo_q;
  logic        push;
  logic        pop;
  logic        flush;
  logic        acc;
  logic        wr_now;
  logic        mapped;
  logic        fault_ev;
  logic [31:0] setup_rd;
  logic [31:0] stat_rd;

  dcc_req_sel #(
    .NREQ(NREQ)
  ) u_sel (
    .periph_req               (periph_req),
    .read_side_request_select (r.rsel),
    .write_side_request_select(r.wsel),
    .flow                     (r.flow),
    .go                       (go)
  );

  dcc_fifo #(
    .W    (32),
    .DEPTH(FDEPTH)
  ) u_fifo (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .push     (push),
    .wdata    (mem_rdata),
    .pop      (pop),
    .flush    (flush),
    .rdata    (fifo_q),
    .not_empty(active),
    .full     (full)
  );

  assign acc    = psel && penable && !r.pready;
  assign wr_now = psel && penable && pwrite && r.pready && !r.pslverr;
  assign mapped = (paddr <= DCC_OFF_CLR) && (paddr[1:0] == 2'h0);

  assign setup_rd = {13'h0, r.halt, active, r.lock, r.done_en, r.fault_en,   // [RULE2]
                     r.flow, 1'b0, r.wsel, 1'b0, r.rsel, r.en};
  assign stat_rd  = {27'h0, active, r.stuck, r.fault_st, r.done_st, r.en};

  always_comb
  begin
    n        = r;
    push     = 1'b0;
    pop      = 1'b0;
    flush    = 1'b0;
    fault_ev = 1'b0;

    // Bus answer: data is captured in the first access cycle, shown with pready.
    n.pready  = acc;
    n.pslverr = acc && !mapped;
    if (acc)
    begin
      unique case (paddr)
        DCC_OFF_SRC:   n.prdata = r.src;
        DCC_OFF_DST:   n.prdata = r.dst;
        DCC_OFF_NXT:   n.prdata = r.nxt;
        DCC_OFF_CTRL:  n.prdata = r.ctrl;
        DCC_OFF_SETUP: n.prdata = setup_rd;
        DCC_OFF_STAT:  n.prdata = stat_rd;
        default:       n.prdata = 32'h0;
      endcase
    end

    // Software clears come first so that a same-cycle event still sets the flag.
    if (wr_now && paddr == DCC_OFF_CLR)
    begin
      if (pwdata[DCC_CLR_DONE])
        n.done_st = 1'b0;                                                     // [RULE20]
      if (pwdata[DCC_CLR_FAULT] && !r.stuck)
        n.fault_st = 1'b0;                                                    // [RULE16]
    end

    unique case (r.st)
      DCC_IDLE:
        n.mem.req = 1'b0;
      DCC_WAIT:
      begin
        n.mem.lock = 1'b0;
        if (r.left == '0)
        begin
          n.st = DCC_IDLE;
          n.en = 1'b0;
        end
        else if (r.en && !r.halt && (go || r.flow == DCC_FLOW_M2M))          // [RULE1] [RULE22] [RULE10]
        begin
          if (dcc_misaligned(r.src, r.ctrl[DCC_SWID_LSB +: 3]) ||
              dcc_misaligned(r.dst, r.ctrl[DCC_DWID_LSB +: 3]))
            fault_ev = 1'b1;                                                  // [RULE16]
          else
          begin
            n.st       = DCC_READ;
            n.beat     = r.ctrl[DCC_BURST_LSB +: 3];
            n.mem.lock = r.lock;                                              // [RULE3]
          end
        end
      end
      DCC_READ, DCC_WRITE, DCC_FETCH:
      begin
        if (!r.mem.req)
        begin
          n.mem.req   = 1'b1;
          n.mem.we    = (r.st == DCC_WRITE);
          n.mem.wdata = fifo_q;
          n.mem.addr  = (r.st == DCC_READ) ? r.src :
                        (r.st == DCC_WRITE) ? r.dst :
                        r.fptr + {28'h0, r.widx, 2'h0};
        end
        else if (mem_ack)
        begin
          n.mem.req = 1'b0;
          if (mem_err)
            fault_ev = 1'b1;
          else if (r.st == DCC_READ)
          begin
            push  = 1'b1;
            n.src = r.src + dcc_step(r.ctrl[DCC_SWID_LSB +: 3]);
            n.st  = DCC_WRITE;
          end
          else if (r.st == DCC_WRITE)
          begin
            pop    = 1'b1;
            n.dst  = r.dst + dcc_step(r.ctrl[DCC_DWID_LSB +: 3]);
            n.left = r.left - 12'h1;
            n.beat = r.beat - 3'h1;
            if (r.left == 12'h1)
            begin
              // Block finished: flag it if the control irq bit is set, then chain or stop.
              if (r.ctrl[DCC_CTRL_IRQ])
                n.done_st = 1'b1;                                             // [RULE19]
              if (r.nxt != DCC_NXT_END)
              begin
                n.st   = DCC_FETCH;                                           // [RULE17]
                n.fptr = r.nxt;
                n.widx = 2'h0;
              end
              else
              begin
                n.st = DCC_IDLE;                                              // [RULE21]
                n.en = 1'b0;                                                  // [RULE11]
              end
              n.mem.lock = 1'b0;
            end
            else if (r.beat == 3'h0)
            begin
              n.st       = DCC_WAIT;
              n.mem.lock = 1'b0;
            end
            else
              n.st = DCC_READ;                                                // [RULE3]
          end
          else
          begin
            unique case (r.widx)                                              // [RULE18]
              2'h0:    n.src  = mem_rdata;
              2'h1:    n.dst  = mem_rdata;
              2'h2:    n.nxt  = mem_rdata;
              default: n.ctrl = mem_rdata;
            endcase
            n.widx = r.widx + 2'h1;
            if (r.widx == DCC_DESC_LAST)
            begin
              n.left = mem_rdata[DCC_CNT_LSB +: DCC_CNT_W];
              n.st   = DCC_WAIT;
            end
          end
        end
      end
      default:
        n.st = DCC_IDLE;
    endcase

    // A bus or alignment error stops the channel; during an unsafe rewrite it sticks.
    if (fault_ev)
    begin
      n.fault_st = 1'b1;                                                      // [RULE16]
      n.stuck    = r.stuck || r.unsafe;
      n.st       = DCC_IDLE;
      n.en       = 1'b0;
      n.mem      = '0;
      flush      = 1'b1;
    end

    if (wr_now)
    begin
      unique case (paddr)
        DCC_OFF_SRC:  n.src  = pwdata;
        DCC_OFF_DST:  n.dst  = pwdata;
        DCC_OFF_NXT:  n.nxt  = pwdata;
        DCC_OFF_CTRL: n.ctrl = pwdata;
        DCC_OFF_SETUP:
        begin
          n.halt     = pwdata[DCC_HALT_BIT];
          n.lock     = pwdata[DCC_LOCK_BIT];
          n.done_en  = pwdata[DCC_DONEEN_BIT];
          n.fault_en = pwdata[DCC_FAULTEN_BIT];
          n.flow     = pwdata[DCC_FLOW_LSB +: 3];                             // [RULE6]
          n.wsel     = pwdata[DCC_WSEL_LSB +: 4];
          n.rsel     = pwdata[DCC_RSEL_LSB +: 4];
          n.en       = pwdata[DCC_EN_BIT];                                    // [RULE9]
          n.unsafe   = r.en && r.halt && pwdata[DCC_EN_BIT];                  // [RULE15]
          if (!r.en && pwdata[DCC_EN_BIT])
          begin
            n.st       = DCC_WAIT;
            n.left     = r.ctrl[DCC_CNT_LSB +: DCC_CNT_W];
            n.mem      = '0;
            n.stuck    = n.stuck;
          end
          else if (!pwdata[DCC_EN_BIT])
          begin
            // Dropping enable abandons the transfer; buffered data is thrown away.
            n.st  = DCC_IDLE;                                                 // [RULE12]
            n.mem = '0;
            flush = 1'b1;                                                     // [RULE12]
          end
        end
        default:
          n.src = n.src;
      endcase
    end

    n.done_irq  = n.done_st && n.done_en;                                     // [RULE4]
    n.fault_irq = n.fault_st && n.fault_en;                                   // [RULE5]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r      <= '0;
      r.src  <= DCC_REG_RST;
      r.dst  <= DCC_REG_RST;
      r.nxt  <= DCC_REG_RST;
      r.ctrl <= DCC_REG_RST;
      r.st   <= DCC_IDLE;
    end
    else if (ce)
      r <= n;
  end

  assign prdata    = r.prdata;
  assign pready    = r.pready;
  assign pslverr   = r.pslverr;
  assign mem_o     = r.mem;
  assign done_irq  = r.done_irq;
  assign fault_irq = r.fault_irq;
endmodule

// ### rtl/dcc_fifo.sv
// Purpose: Channel data FIFO held in flip-flops.
// Assumes: Push and pop are never asked when full or empty.
// Notes: Flush empties it at once; data in it is lost.
module dcc_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic         push,
  input  wire logic [W-1:0] wdata,
  input  wire logic         pop,
  input  wire logic         flush,
  output logic      [W-1:0] rdata,
  output logic              not_empty,
  output logic              full
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
  } dcc_fifo_s;
  dcc_fifo_s r, n;

  always_comb
  begin
    n = r;
    if (flush)
    begin
      n.wr  = '0;
      n.rd  = '0;
      n.cnt = '0;
    end
    else
    begin
      if (push && !full)
      begin
        n.mem[r.wr] = wdata;
        n.wr        = (r.wr == AW'(DEPTH - 1)) ? '0 : r.wr + 1'b1;
      end
      if (pop && not_empty)
        n.rd = (r.rd == AW'(DEPTH - 1)) ? '0 : r.rd + 1'b1;
      n.cnt = r.cnt + (AW+1)'(push && !full) - (AW+1)'(pop && not_empty);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else if (ce)
      r <= n;
  end

  assign rdata     = r.mem[r.rd];
  assign not_empty = (r.cnt != '0);
  assign full      = (r.cnt == (AW+1)'(DEPTH));
endmodule

// ### rtl/dcc_req_sel.sv
// Purpose: Picks the peripheral request lines that pace a channel.
// Assumes: Request lines are synchronous to pclk.
// Notes: A memory side never waits, so its select is ignored.
module dcc_req_sel #(
  parameter int NREQ = 16
) (
  input  wire logic [NREQ-1:0] periph_req,
  input  wire logic [3:0]      read_side_request_select,
  input  wire logic [3:0]      write_side_request_select,
  input  wire logic [2:0]      flow,
  output logic                 go
);
  import dcc_pkg::*;
  logic rd_ok;
  logic wr_ok;

  assign rd_ok = dcc_src_is_mem(flow) || periph_req[read_side_request_select];   // [RULE8]
  assign wr_ok = dcc_dst_is_mem(flow) || periph_req[write_side_request_select];  // [RULE7]
  assign go    = rd_ok && wr_ok && (flow <= DCC_FLOW_P2P);                       // [RULE6]
endmodule

// ### shared/dcc_pkg.sv
// Purpose: Constants, types and helpers shared by the DMA channel files.
// Assumes: One channel, APB register access, one word per FIFO beat.
// Notes: Offsets are byte addresses on a 32-bit APB.
// Contract
// [RULE1] Halt set makes channel ignore new requests.
// [RULE2] Active bit reads one while FIFO holds data.
// [RULE3] Lock keeps bus through whole burst sequence.
// [RULE4] Done mask bit gates terminal-count interrupt.
// [RULE5] Fault mask bit gates bus error interrupt.
// [RULE6] Three-bit direction field selects transfer type.
// [RULE7] Write-side select ignored when destination is memory.
// [RULE8] Read-side select ignored when source is memory.
// [RULE9] Enable bit switches channel, starts memory copies.
// [RULE10] Memory copies start only by software enable.
// [RULE11] Hardware clears enable when count is moved.
// [RULE12] Disabling mid-transfer discards FIFO contents.
// [RULE13] Software reinitializes channels after an abort.
// [RULE14] Pause: halt, wait inactive, then disable.
// [RULE15] Disable before rewriting a halted enabled channel.
// [RULE16] Misaligned width raises error; unsafe case sticks.
// [RULE17] Chaining reloads registers from memory descriptor.
// [RULE18] Descriptor: source, destination, next, control.
// [RULE19] Descriptor control bit raises done at block end.
// [RULE20] Software clears done flag through clear register.
// [RULE21] Zero next pointer ends the chain.
// [RULE22] Serve requests only when enabled and not halted.
// [RULE23] Software writes zero to unused bits.
package dcc_pkg;
  localparam logic [7:0] DCC_OFF_SRC   = 8'h00;
  localparam logic [7:0] DCC_OFF_DST   = 8'h04;
  localparam logic [7:0] DCC_OFF_NXT   = 8'h08;
  localparam logic [7:0] DCC_OFF_CTRL  = 8'h0c;
  localparam logic [7:0] DCC_OFF_SETUP = 8'h10;
  localparam logic [7:0] DCC_OFF_STAT  = 8'h14;
  localparam logic [7:0] DCC_OFF_CLR   = 8'h18;
  localparam int DCC_EN_BIT      = 0;
  localparam int DCC_RSEL_LSB    = 1;
  localparam int DCC_WSEL_LSB    = 6;
  localparam int DCC_FLOW_LSB    = 11;
  localparam int DCC_FAULTEN_BIT = 14;
  localparam int DCC_DONEEN_BIT  = 15;
  localparam int DCC_LOCK_BIT    = 16;
  localparam int DCC_ACTIVE_BIT  = 17;
  localparam int DCC_HALT_BIT    = 18;
  localparam int DCC_CNT_LSB     = 0;
  localparam int DCC_CNT_W       = 12;
  localparam int DCC_BURST_LSB   = 12;
  localparam int DCC_SWID_LSB    = 18;
  localparam int DCC_DWID_LSB    = 21;
  localparam int DCC_CTRL_IRQ    = 31;
  localparam int DCC_ST_ON       = 0;
  localparam int DCC_ST_DONE     = 1;
  localparam int DCC_ST_FAULT    = 2;
  localparam int DCC_ST_STUCK    = 3;
  localparam int DCC_ST_ACTIVE   = 4;
  localparam int DCC_CLR_DONE    = 0;
  localparam int DCC_CLR_FAULT   = 1;
  localparam logic [31:0] DCC_REG_RST = 32'h0000_0000;
  localparam logic [31:0] DCC_NXT_END = 32'h0000_0000;
  localparam logic [31:0] DCC_WORD_BYTES = 32'h0000_0004;
  localparam logic [1:0]  DCC_DESC_LAST  = 2'h3;
  localparam logic [2:0] DCC_FLOW_M2M = 3'h0;
  localparam logic [2:0] DCC_FLOW_M2P = 3'h1;
  localparam logic [2:0] DCC_FLOW_P2M = 3'h2;
  localparam logic [2:0] DCC_FLOW_P2P = 3'h3;

  typedef enum logic [2:0] {DCC_IDLE, DCC_WAIT, DCC_READ, DCC_WRITE, DCC_FETCH} dcc_state_e;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        lock;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dcc_mem_req_s;

  function automatic logic dcc_src_is_mem(input logic [2:0] flow);
    return (flow == DCC_FLOW_M2M) || (flow == DCC_FLOW_M2P);
  endfunction

  function automatic logic dcc_dst_is_mem(input logic [2:0] flow);
    return (flow == DCC_FLOW_M2M) || (flow == DCC_FLOW_P2M);
  endfunction

  function automatic logic [31:0] dcc_step(input logic [2:0] wcode);
    return (wcode == 3'h0) ? 32'h1 : (wcode == 3'h1) ? 32'h2 : 32'h4;
  endfunction

  function automatic logic dcc_misaligned(input logic [31:0] addr, input logic [2:0] wcode);
    return (wcode > 3'h2) || ((addr & (dcc_step(wcode) - 32'h1)) != 32'h0);
  endfunction
endpackage

// ### testbench/dcc_chk.sv
// Purpose: Port checks for the DMA channel.
// Assumes: The clock enable stays high, so every edge counts.
// Notes: Mask checks allow two edges, as the irq outputs are registered.
module dcc_chk
  import dcc_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire dcc_pkg::dcc_mem_req_s mem_o,
  input wire logic                  mem_ack,
  input wire logic                  mem_err,
  input wire logic                  done_irq,
  input wire logic                  fault_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready;
  wire setup_wr = acc && pwrite && (paddr == DCC_OFF_SETUP);

  a_apb_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  a_req_hold: assert property (mem_o.req && !mem_ack |=>
    mem_o.req && $stable(mem_o.addr) && $stable(mem_o.we) && $stable(mem_o.wdata))
    else $error("memory request changed before ack");
  a_req_drop: assert property (mem_o.req && mem_ack |=> !mem_o.req)
    else $error("memory request kept after ack");
  a_lock_held: assert property (mem_o.lock && mem_o.req && mem_ack && !mem_err && !mem_o.we |=> mem_o.lock)
    else $error("lock dropped inside a locked burst");
  a_done_masked: assert property (setup_wr && !pwdata[DCC_DONEEN_BIT] |=> ##1 !done_irq)
    else $error("done irq seen while masked");
  a_fault_masked: assert property (setup_wr && !pwdata[DCC_FAULTEN_BIT] |=> ##1 !fault_irq)
    else $error("fault irq seen while masked");
  a_err_stops: assert property (mem_o.req && mem_ack && mem_err |=> !mem_o.req [*3])
    else $error("channel went on after bus error");
  a_setup_spare: assert property (acc && !pwrite && paddr == DCC_OFF_SETUP |->
    prdata[31:19] == 13'h0 && !prdata[10] && !prdata[5])
    else $error("unused setup bits read non zero");

  cover property ($rose(done_irq));
  cover property ($rose(fault_irq));
  cover property (mem_o.req && mem_o.lock);
endmodule

bind dcc_channel dcc_chk u_dcc_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .mem_o(mem_o),
  .mem_ack(mem_ack), .mem_err(mem_err), .done_irq(done_irq), .fault_irq(fault_irq));

// ### testbench/dcc_mem.sv
// Purpose: Behavioural system memory on the channel's master port.
// Assumes: Byte addressed (bits 8:2 pick the word), 128 words, lat wait cycles before each ack.
// Notes: Read data turns over every idle cycle so stale data never passes.
module dcc_mem (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic [3:0]            lat,
  input wire logic [31:0]           bad_addr,
  input wire dcc_pkg::dcc_mem_req_s bus,
  output logic                      ack,
  output logic [31:0]               rdata,
  output logic                      err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [128];
  logic [3:0]  cnt;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack <= 1'b0;
      err <= 1'b0;
      cnt <= 4'h0;
      rdata <= 32'h0;
    end
    else
    begin
      ack <= 1'b0;
      err <= 1'b0;
      rdata <= ~rdata;
      if (bus.req && !ack)
      begin
        cnt <= cnt + 4'h1;
        if (cnt >= lat)
        begin
          cnt <= 4'h0;
          ack <= 1'b1;
          err <= (bus.addr == bad_addr);
          if (!bus.we)
            rdata <= mem[bus.addr[8:2]];
          else if (bus.addr != bad_addr)
            mem[bus.addr[8:2]] <= bus.wdata;
        end
      end
    end
  end
endmodule

// ### testbench/test_dcc_channel.sv
// Purpose: Self-checking bench for one DMA channel.
// Assumes: Clock enable tied high; software steps follow the safe order, except the unsafe halted rewrite in t_fault.
// Notes: Completion waits poll the status register; only the no-transfer checks in t_p2m use fixed 20-cycle waits.
module test_dcc_channel;
  timeunit 1ns;
  timeprecision 1ps;
  import dcc_pkg::*;
  logic         pclk = 1'b0;
  logic         presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic         mem_ack, mem_err, done_irq, fault_irq;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, mem_rdata, q, bad_addr;
  logic [15:0]  periph_req;
  logic [3:0]   lat;
  dcc_mem_req_s mem_o;
  int           n_fail = 0;
  int           tests_run = 0;
  logic         seen = 1'b0;

  always #12.5 pclk = ~pclk;

  dcc_channel u_dcc_channel (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_req(periph_req), .mem_o(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_err(mem_err),
    .done_irq(done_irq), .fault_irq(fault_irq));
  dcc_mem u_dcc_mem (.pclk(pclk), .presetn(presetn), .lat(lat), .bad_addr(bad_addr), .bus(mem_o),
    .ack(mem_ack), .rdata(mem_rdata), .err(mem_err));

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    check("apb answer", 32'h1, 32'(pready));
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, e, q);
  endtask

  task automatic prog(input logic [31:0] s, input logic [31:0] d, input logic [31:0] n, input logic [31:0] c);
    apb(1'b1, DCC_OFF_SRC, s);
    apb(1'b1, DCC_OFF_DST, d);
    apb(1'b1, DCC_OFF_NXT, n);
    apb(1'b1, DCC_OFF_CTRL, c);
  endtask

  task automatic idle;
    int n;
    n = 0;
    do begin apb(1'b0, DCC_OFF_STAT, 32'h0); seen |= q[DCC_ST_ACTIVE]; n++; end while (q[DCC_ST_ON] !== 1'b0 && n < 60);
    check("channel idle", 32'h0, 32'(q[DCC_ST_ON]));
  endtask

  task automatic t_regs;
    for (int a = 0; a < 7; a++)
      rd(8'(a * 4), DCC_REG_RST, "reset value");
    apb(1'b1, DCC_OFF_SETUP, 32'h0005_fbde);
    rd(DCC_OFF_SETUP, 32'h0005_fbde, "setup fields");
    apb(1'b1, DCC_OFF_SETUP, 32'h0);
    apb(1'b1, DCC_OFF_STAT, 32'hffff_ffff);
    rd(DCC_OFF_STAT, 32'h0, "status read only");
    rd(8'h1c, 32'h0, "unmapped read");
    check("unmapped error", 32'h1, 32'(serr));
    $display("test regs done");
  endtask

  task automatic t_m2m;
    for (int m = 0; m < 2; m++)
    begin
      u_dcc_mem.mem[16] = 32'h1111_0000 + m;
      u_dcc_mem.mem[17] = 32'h2222_0000 + m;
      prog(32'h40, 32'h80, DCC_NXT_END, 32'h8048_0002);
      apb(1'b1, DCC_OFF_SETUP, m ? 32'h0001_8001 : 32'h1);
      idle;
      check("copy word 0", 32'h1111_0000 + m, u_dcc_mem.mem[32]);
      check("copy word 1", 32'h2222_0000 + m, u_dcc_mem.mem[33]);
      rd(DCC_OFF_SETUP, m ? 32'h0001_8000 : 32'h0, "enable auto clear");
      check("done irq", 32'(m), 32'(done_irq));
      rd(DCC_OFF_STAT, 32'h2, "done flag");
      apb(1'b1, DCC_OFF_CLR, 32'h1);
      rd(DCC_OFF_STAT, 32'h0, "done cleared");
      check("done irq cleared", 32'h0, 32'(done_irq));
    end
    $display("test m2m done");
  endtask

  task automatic t_p2m;
    u_dcc_mem.mem[0] = 32'h5a5a_0003;
    u_dcc_mem.mem[48] = 32'h0;
    lat <= 4'h3;
    prog(32'h0, 32'hc0, DCC_NXT_END, 32'h0048_0001);
    periph_req <= 16'h0008;
    apb(1'b1, DCC_OFF_SETUP, 32'h0004_1147);
    repeat (20) @(posedge pclk);
    check("halted no move", 32'h0, u_dcc_mem.mem[48]);
    rd(DCC_OFF_SETUP, 32'h0004_1147, "fifo empty");
    apb(1'b1, DCC_OFF_SETUP, 32'h0);
    prog(32'h0, 32'hc0, DCC_NXT_END, 32'h0048_0001);
    periph_req <= 16'hfff7;
    apb(1'b1, DCC_OFF_SETUP, 32'h0000_1147);
    repeat (20) @(posedge pclk);
    check("other lines ignored", 32'h0, u_dcc_mem.mem[48]);
    periph_req <= 16'h0008;
    seen = 1'b0;
    idle;
    check("peripheral word", 32'h5a5a_0003, u_dcc_mem.mem[48]);
    check("fifo data flag", 32'h1, 32'(seen));
    lat <= 4'h0;
    $display("test p2m done");
  endtask

  task automatic t_fault;
    for (int m = 0; m < 2; m++)
    begin
      bad_addr <= 32'h100;
      u_dcc_mem.mem[64] = 32'h0;
      prog(m ? 32'h102 : 32'h100, 32'h140, DCC_NXT_END, 32'h0048_0001);
      apb(1'b1, DCC_OFF_SETUP, m ? 32'h4001 : 32'h1);
      idle;
      check("fault irq", 32'(m), 32'(fault_irq));
      rd(DCC_OFF_STAT, 32'h4, "fault flag");
      apb(1'b1, DCC_OFF_CLR, 32'h2);
      rd(DCC_OFF_STAT, 32'h0, "fault cleared");
      bad_addr <= 32'hffff_fff0;
    end
    prog(32'h102, 32'h140, DCC_NXT_END, 32'h0048_0001);
    apb(1'b1, DCC_OFF_SETUP, 32'h0004_0001);
    apb(1'b1, DCC_OFF_SETUP, 32'h0000_0001);
    idle;
    apb(1'b1, DCC_OFF_CLR, 32'h2);
    rd(DCC_OFF_STAT, 32'hc, "fault stuck");
    $display("test fault done");
  endtask

  task automatic t_chain;
    u_dcc_mem.mem[20] = 32'h0dd0_0001;
    u_dcc_mem.mem[24] = 32'h0dd0_0002;
    u_dcc_mem.mem[64] = 32'h60;
    u_dcc_mem.mem[65] = 32'h1c0;
    u_dcc_mem.mem[66] = DCC_NXT_END;
    u_dcc_mem.mem[67] = 32'h8048_0001;
    prog(32'h50, 32'h180, 32'h100, 32'h0048_0001);
    apb(1'b1, DCC_OFF_SETUP, 32'h0001_8001);
    idle;
    check("first block", 32'h0dd0_0001, u_dcc_mem.mem[96]);
    check("chained block", 32'h0dd0_0002, u_dcc_mem.mem[112]);
    rd(DCC_OFF_NXT, DCC_NXT_END, "chain end");
    check("block irq", 32'h1, 32'(done_irq));
    apb(1'b1, DCC_OFF_CLR, 32'h1);
    $display("test chain done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // The whole run takes well under a thousand cycles; this bound is generous.
  initial
  begin
    repeat (30000) @(posedge pclk);
    n_fail++;
    close_out;
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    periph_req = 16'h0;
    lat = 4'h1;
    bad_addr = 32'hffff_fff0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_m2m;
    t_p2m;
    t_fault;
    t_chain;
    close_out;
  end
endmodule
